// ### src/bdc_pkg.sv
/*
 Package for the bridge diagnostic and chip control register bank: offsets, bit positions, reset values, timing counts, carriers.
 Assumes a single 250 MHz clock domain; timeouts are counted in PCI clocks signalled by a one-cycle enable.
*/
package bdc_pkg;

	// Register byte offsets
	localparam logic [7:0] BDC_OFS_DIAG = 8'h40;
	localparam logic [7:0] BDC_OFS_BCTL = 8'h3C;
	localparam logic [7:0] BDC_OFS_IRQ_STAT = 8'h80;
	localparam logic [7:0] BDC_OFS_IRQ_MASK = 8'h84;

	// Bridge control upper field positions
	localparam int BDC_BIT_PRI_TMO_SEL = 24;
	localparam int BDC_BIT_SEC_TMO_SEL = 25;
	localparam int BDC_BIT_TMO_STAT = 26;
	localparam int BDC_BIT_DISC_SERR_EN = 27;

	// Diag_chip_control field positions
	localparam int BDC_BIT_WR_DISC = 1;
	localparam int BDC_BIT_PF_DIS = 4;
	localparam int BDC_BIT_LIVE_INS = 5;
	localparam int BDC_BIT_CHIP_RST = 8;
	localparam int BDC_BIT_CTR_TEST_LO = 9;

	// Interrupt status bit positions
	localparam int BDC_IRQ_PRI_TMO = 0;
	localparam int BDC_IRQ_SEC_TMO = 1;
	localparam int BDC_IRQ_DISC = 2;
	localparam int BDC_IRQ_RST_DONE = 3;
	localparam int BDC_IRQ_W = 4;

	// Reset values
	localparam logic [31:0] BDC_BCTL_RST = 32'h0000_0000;
	localparam logic [15:0] BDC_DIAG_RST = 16'h0000;
	localparam logic [1:0] BDC_CTR_TEST_RST = 2'h0;

	// Timeout lengths as exponents of two, in PCI clocks
	localparam int BDC_TMO_LONG_EXP = 15;
	localparam int BDC_TMO_SHORT_EXP = 10;
	localparam logic [15:0] BDC_TMO_LONG = 16'h8000;
	localparam logic [15:0] BDC_TMO_SHORT = 16'h0400;

	// Chip reset pulse length in ns and its cycle count at 250 MHz
	localparam int BDC_CLK_MHZ = 250;
	localparam int BDC_RST_NS = 1000;
	localparam int BDC_RST_CYCLES = (BDC_RST_NS * BDC_CLK_MHZ + 999) / 1000;

	// Delayed-transaction queue head events of one port
	typedef struct packed {
		logic head;     // Transaction sits at the front of the queue
		logic repeated; // Initiator repeated the request
		logic done;     // Transaction left the queue normally
	} bdc_dt_t;

	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bdc_bus_t;

endpackage

// ### src/bdc_ctrl.sv
/*
 Bridge diag_chip_control register bank with master timeout counters and interrupt status.
 Assumes a simple register port (read data one cycle after the read strobe) and a pci_tick enable per PCI clock.
*/
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module bdc_ctrl
	import bdc_pkg::*;
#(
	parameter int RST_CYCLES = BDC_RST_CYCLES
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Register port
	input wire bdc_bus_t bus,
	output logic [31:0] rdata,
	// PCI clock enable
	input wire logic pci_tick,
	// Delayed transactions, primary and secondary
	input wire bdc_dt_t pri_dt,
	input wire bdc_dt_t sec_dt,
	output logic pri_discard,
	output logic sec_discard,
	// Discard timers
	input wire logic pri_disc_expire,
	input wire logic sec_disc_expire,
	output logic primary_system_error_n,
	// Command register and live insertion pin
	input wire logic io_en_in,
	input wire logic mem_en_in,
	input wire logic master_en_in,
	input wire logic gpio3_in,
	input wire logic gpio3_is_input,
	output logic io_en_eff,
	output logic mem_en_eff,
	output logic master_en_eff,
	output logic accept_io,
	output logic accept_mem,
	// Data path controls
	output logic wr_disc_cacheline,
	output logic upstream_prefetch,
	output logic forward_byte_en,
	output logic single_dword,
	output logic [1:0] ctr_test_sel,
	// Chip reset
	output logic chip_reset,
	output logic sec_bus_reset_n,
	// Interrupt
	output logic irq
);

	// Control storage
	logic pri_tmo_sel_reg;   // Primary timeout select
	logic sec_tmo_sel_reg;   // Secondary timeout select
	logic tmo_stat_reg;      // Timeout status flag
	logic disc_serr_en_reg;  // Discard timer error enable
	logic wr_disc_reg;       // Write disconnect select
	logic pf_dis_reg;        // Prefetch disable
	logic live_ins_reg;      // Live insertion mode
	logic chip_rst_reg;      // Chip reset in progress
	logic [1:0] ctr_test_reg; // Counter test select, read-only
	logic [BDC_IRQ_W-1:0] irq_stat_reg; // Sticky events
	logic [BDC_IRQ_W-1:0] irq_mask_reg; // Interrupt enables
	logic [1:0] disc_reg; // Discard pulses, bit 0 primary, bit 1 secondary
	logic [15:0] rst_cnt_reg; // Chip reset sequence counter
	logic serr_reg;           // System error drive

	// Decoded strobes and events
	logic wr_bctl;
	logic wr_diag;
	logic wr_mask;
	logic rd_stat;
	logic [1:0] hit; // Timeout expiry per port, bit 0 primary
	logic [1:0] tmo_sel; // Timeout select per port
	bdc_dt_t dt [2]; // Queue events per port
	logic rst_done;
	logic [BDC_IRQ_W-1:0] irq_ev;
	logic live_mask;
	logic [31:0] bctl_view;
	logic [15:0] diag_view;

	// Address decode for writes and status reads
	always_comb
	begin
		wr_bctl = bus.wr && (bus.addr == BDC_OFS_BCTL);
		wr_diag = bus.wr && (bus.addr == BDC_OFS_DIAG);
		wr_mask = bus.wr && (bus.addr == BDC_OFS_IRQ_MASK);
		rd_stat = bus.rd && (bus.addr == BDC_OFS_IRQ_STAT);
	end

	// Per-port copies of the timeout selects and queue events
	assign tmo_sel = {sec_tmo_sel_reg, pri_tmo_sel_reg};
	assign dt[0] = pri_dt;
	assign dt[1] = sec_dt;

	// Master timeout per port: counts PCI clocks only while its transaction heads the queue
	for (genvar p = 0; p < 2; p++)
	begin : g_tmo
		logic [15:0] lim; // Limit in PCI clocks
		logic [15:0] cnt_reg; // Timeout counter
		logic run_reg; // Counter armed
		logic rep_reg; // Initiator repeated at least once
		assign lim = tmo_sel[p] ? BDC_TMO_SHORT : BDC_TMO_LONG;
		// Head needed too, so a stalled count cannot expire once the transaction left the front
		assign hit[p] = dt[p].head && run_reg && pci_tick && (cnt_reg == lim - 16'h0001);
		always_ff @(posedge sys_clk)
		begin
			if (!resetn || chip_rst_reg || dt[p].done || hit[p])
			begin
				// Reset, transaction left the queue, or timed out
				cnt_reg <= 16'h0000;
				run_reg <= 1'b0;
				rep_reg <= 1'b0;
			end
			else if (dt[p].head)
			begin
				run_reg <= 1'b1;
				if (dt[p].repeated)
				begin
					rep_reg <= 1'b1;
				end
				if (run_reg && pci_tick)
				begin
					cnt_reg <= cnt_reg + 16'h0001;
				end
			end
		end
		// Discard pulse when no repeat came before expiry
		always_ff @(posedge sys_clk)
		begin
			if (!resetn)
			begin
				disc_reg[p] <= 1'b0;
			end
			else
			begin
				disc_reg[p] <= hit[p] && !rep_reg && !dt[p].repeated;
			end
		end
	end
	assign pri_discard = disc_reg[0];
	assign sec_discard = disc_reg[1];

	// Bridge control upper: select bits and error enable
	always_ff @(posedge sys_clk)
	begin
		if (!resetn || chip_rst_reg)
		begin
			pri_tmo_sel_reg <= BDC_BCTL_RST[BDC_BIT_PRI_TMO_SEL];
			sec_tmo_sel_reg <= BDC_BCTL_RST[BDC_BIT_SEC_TMO_SEL];
			disc_serr_en_reg <= BDC_BCTL_RST[BDC_BIT_DISC_SERR_EN];
		end
		else if (wr_bctl)
		begin
			pri_tmo_sel_reg <= bus.wdata[BDC_BIT_PRI_TMO_SEL];
			sec_tmo_sel_reg <= bus.wdata[BDC_BIT_SEC_TMO_SEL];
			disc_serr_en_reg <= bus.wdata[BDC_BIT_DISC_SERR_EN];
		end
	end

	// Timeout status: expiry sets, write one clears, set wins
	always_ff @(posedge sys_clk)
	begin
		if (!resetn || chip_rst_reg)
		begin
			tmo_stat_reg <= 1'b0;
		end
		else if (|hit)
		begin
			tmo_stat_reg <= 1'b1;
		end
		else if (wr_bctl && bus.wdata[BDC_BIT_TMO_STAT])
		begin
			tmo_stat_reg <= 1'b0;
		end
	end

	// System error output, registered
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			serr_reg <= 1'b0;
		end
		else
		begin
			serr_reg <= disc_serr_en_reg && (pri_disc_expire || sec_disc_expire);
		end
	end
	assign primary_system_error_n = !serr_reg;

	// Diag_chip_control fields
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			wr_disc_reg <= BDC_DIAG_RST[BDC_BIT_WR_DISC];
			pf_dis_reg <= BDC_DIAG_RST[BDC_BIT_PF_DIS];
			live_ins_reg <= BDC_DIAG_RST[BDC_BIT_LIVE_INS];
			ctr_test_reg <= BDC_CTR_TEST_RST;
		end
		else if (chip_rst_reg)
		begin
			wr_disc_reg <= BDC_DIAG_RST[BDC_BIT_WR_DISC];
			pf_dis_reg <= BDC_DIAG_RST[BDC_BIT_PF_DIS];
			live_ins_reg <= BDC_DIAG_RST[BDC_BIT_LIVE_INS];
		end
		else if (wr_diag)
		begin
			wr_disc_reg <= bus.wdata[BDC_BIT_WR_DISC];
			pf_dis_reg <= bus.wdata[BDC_BIT_PF_DIS];
			live_ins_reg <= bus.wdata[BDC_BIT_LIVE_INS];
		end
	end

	// Chip reset sequence, self-clearing
	assign rst_done = chip_rst_reg && (rst_cnt_reg == 16'(RST_CYCLES - 1));
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			chip_rst_reg <= 1'b0;
			rst_cnt_reg <= 16'h0000;
		end
		else if (rst_done)
		begin
			chip_rst_reg <= 1'b0;
			rst_cnt_reg <= 16'h0000;
		end
		else if (chip_rst_reg)
		begin
			rst_cnt_reg <= rst_cnt_reg + 16'h0001;
		end
		else if (wr_diag && bus.wdata[BDC_BIT_CHIP_RST])
		begin
			chip_rst_reg <= 1'b1;
		end
	end
	assign chip_reset = chip_rst_reg;
	assign sec_bus_reset_n = !chip_rst_reg;

	// Data path controls
	assign wr_disc_cacheline = wr_disc_reg;
	assign upstream_prefetch = !pf_dis_reg;
	assign forward_byte_en = pf_dis_reg;
	assign single_dword = pf_dis_reg;
	assign ctr_test_sel = ctr_test_reg;

	// Live insertion masking of command enables
	assign live_mask = live_ins_reg && gpio3_is_input && gpio3_in;
	assign io_en_eff = io_en_in && !live_mask;
	assign mem_en_eff = mem_en_in && !live_mask;
	assign master_en_eff = master_en_in && !live_mask;
	assign accept_io = io_en_eff && !chip_rst_reg;
	assign accept_mem = mem_en_eff && !chip_rst_reg;

	// Interrupt events, mask and sticky status cleared by read
	always_comb
	begin
		irq_ev = '0;
		irq_ev[BDC_IRQ_PRI_TMO] = hit[0];
		irq_ev[BDC_IRQ_SEC_TMO] = hit[1];
		irq_ev[BDC_IRQ_DISC] = pri_disc_expire || sec_disc_expire;
		irq_ev[BDC_IRQ_RST_DONE] = rst_done;
	end
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			irq_stat_reg <= '0;
		end
		else if (rd_stat)
		begin
			irq_stat_reg <= irq_ev; // New events survive the clearing read
		end
		else
		begin
			irq_stat_reg <= irq_stat_reg | irq_ev;
		end
	end
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			irq_mask_reg <= '0;
		end
		else if (wr_mask)
		begin
			irq_mask_reg <= bus.wdata[BDC_IRQ_W-1:0];
		end
	end
	assign irq = |(irq_stat_reg & irq_mask_reg);

	// Register views, reserved bits zero
	always_comb
	begin
		bctl_view = '0;
		bctl_view[BDC_BIT_PRI_TMO_SEL] = pri_tmo_sel_reg;
		bctl_view[BDC_BIT_SEC_TMO_SEL] = sec_tmo_sel_reg;
		bctl_view[BDC_BIT_TMO_STAT] = tmo_stat_reg;
		bctl_view[BDC_BIT_DISC_SERR_EN] = disc_serr_en_reg;
		diag_view = '0;
		diag_view[BDC_BIT_WR_DISC] = wr_disc_reg;
		diag_view[BDC_BIT_PF_DIS] = pf_dis_reg;
		diag_view[BDC_BIT_LIVE_INS] = live_ins_reg;
		diag_view[BDC_BIT_CHIP_RST] = chip_rst_reg;
		diag_view[BDC_BIT_CTR_TEST_LO+1:BDC_BIT_CTR_TEST_LO] = ctr_test_reg;
	end

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			rdata <= 32'h0000_0000;
		end
		else if (!bus.rd)
		begin
			rdata <= 32'h0000_0000;
		end
		else if (bus.addr == BDC_OFS_BCTL)
		begin
			rdata <= bctl_view;
		end
		else if (bus.addr == BDC_OFS_DIAG)
		begin
			rdata <= {16'h0000, diag_view};
		end
		else if (bus.addr == BDC_OFS_IRQ_STAT)
		begin
			rdata <= {{(32-BDC_IRQ_W){1'b0}}, irq_stat_reg};
		end
		else if (bus.addr == BDC_OFS_IRQ_MASK)
		begin
			rdata <= {{(32-BDC_IRQ_W){1'b0}}, irq_mask_reg};
		end
		else
		begin
			rdata <= 32'h0000_0000; // Unmapped reads zero
		end
	end

endmodule // bdc_ctrl

// ### bench/bdc_ctrl_checker.sv
/*
 Checker for the port relations of bdc_ctrl.
 Assumes a bind to bdc_ctrl and one clock domain.
*/
`timescale 1ns/1ps
module bdc_ctrl_checker
	import bdc_pkg::*;
(
	// Clock, reset and register port
	input wire logic sys_clk,
	input wire logic resetn,
	input wire bdc_bus_t bus,
	input wire logic [31:0] rdata,
	// Timeout and discard events
	input wire bdc_dt_t pri_dt,
	input wire logic pri_discard,
	input wire logic pri_disc_expire,
	input wire logic sec_disc_expire,
	input wire logic primary_system_error_n,
	// Enables
	input wire logic io_en_in,
	input wire logic gpio3_in,
	input wire logic gpio3_is_input,
	input wire logic io_en_eff,
	input wire logic accept_io,
	// Data path and reset outputs
	input wire logic upstream_prefetch,
	input wire logic forward_byte_en,
	input wire logic single_dword,
	input wire logic [1:0] ctr_test_sel,
	input wire logic chip_reset,
	input wire logic sec_bus_reset_n
);
	// One domain for all checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	a_disc_at_head: assert property (pri_discard |-> $past(pri_dt.head))
		else $error("discard without head");
	a_disc_pulse: assert property (pri_discard |=> !pri_discard)
		else $error("discard longer than one cycle");
	a_serr_cause: assert property (!primary_system_error_n |-> $past(pri_disc_expire || sec_disc_expire))
		else $error("system error without expiry");
	a_rdata_slot: assert property (!$past(bus.rd) |-> rdata == 32'h0)
		else $error("read data outside its slot");
	a_prefetch_mode: assert property (upstream_prefetch != forward_byte_en)
		else $error("prefetch and byte enables agree");
	a_single_dword: assert property (single_dword == forward_byte_en)
		else $error("single dword mode mismatch");
	a_io_masked: assert property (!io_en_in |-> !io_en_eff)
		else $error("io enable raised");
	a_io_unmasked: assert property ((!gpio3_in || !gpio3_is_input) |-> io_en_eff == io_en_in)
		else $error("io enable masked without pin");
	a_io_accept: assert property (accept_io |-> io_en_eff && !chip_reset)
		else $error("io accepted while masked");
	a_sec_reset: assert property (sec_bus_reset_n == !chip_reset)
		else $error("secondary reset mismatch");
	a_ctr_test: assert property (ctr_test_sel == 2'h0)
		else $error("counter test field not zero");
endmodule // bdc_ctrl_checker

bind bdc_ctrl bdc_ctrl_checker chk_i (.*);

// ### bench/bdc_host.sv
/*
 Host model: register port master and PCI clock enable.
 Assumes tasks start right after a rising edge of sys_clk.
*/
`timescale 1ns/1ps
module bdc_host
	import bdc_pkg::*;
(
	// Clock
	input wire logic sys_clk,
	// Register port
	output bdc_bus_t bus,
	input wire logic [31:0] rdata,
	// PCI clock enable
	output logic pci_tick
);
	// Idle bus, one PCI clock per cycle
	initial
	begin
		bus = '0;
		pci_tick = 1'b1;
	end
	// Write strobe for one cycle, then scrambled idle lines
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus <= {a, d, 2'b10};
		@(posedge sys_clk);
		bus <= {~a, ~d, 2'b00};
		@(posedge sys_clk);
	endtask
	// Read strobe; data taken in the following cycle only
	task rd(input logic [7:0] a, output logic [31:0] d);
		bus <= {a, 32'h0, 2'b01};
		@(posedge sys_clk);
		bus <= {~a, 32'hFFFFFFFF, 2'b00};
		#1 d = rdata;
		@(posedge sys_clk);
	endtask
endmodule // bdc_host

// ### bench/tb.sv
/*
 Testbench for bdc_ctrl: register rows, then event cases.
 Assumes bdc_host drives the register port.
*/
`timescale 1ns/1ps
module tb;
	import bdc_pkg::*;
	// Design signals
	logic sys_clk = 1'b0, resetn = 1'b0, pci_tick;
	bdc_bus_t bus;
	logic [31:0] rdata, v;
	bdc_dt_t pri_dt = '0, sec_dt = '0;
	logic pri_disc_expire = 1'b0, sec_disc_expire = 1'b0, gpio3_in = 1'b0, gpio3_is_input = 1'b1;
	logic io_en_in = 1'b1, mem_en_in = 1'b1, master_en_in = 1'b1, sd;
	logic pri_discard, sec_discard, primary_system_error_n, io_en_eff, mem_en_eff, master_en_eff;
	logic accept_io, accept_mem, wr_disc_cacheline, upstream_prefetch, forward_byte_en, single_dword;
	logic chip_reset, sec_bus_reset_n, irq;
	logic [1:0] ctr_test_sel;
	int bad_count = 0, tests_run = 0, n, ns;
	// Row: address, write data, expected read back
	typedef struct packed { logic [7:0] a; logic [31:0] d, e; } bdc_row_t;
	bdc_row_t rows [4] = '{
		'{BDC_OFS_BCTL, 32'hFFFFFFFF, 32'h0B000000},
		'{8'h44, 32'hFFFFFFFF, 32'h0},
		'{BDC_OFS_BCTL, 32'h0, 32'h0},
		'{BDC_OFS_DIAG, 32'hFFFFFEFF, 32'h32}};
	// Clock
	always #2 sys_clk = ~sys_clk;
	bdc_ctrl #(.RST_CYCLES(4)) bdc_ctrl_i (.*);
	bdc_host bdc_host_i (.*);
	// Compare and count
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	// Read and compare
	task rdc(input logic [7:0] a, input logic [31:0] e);
		bdc_host_i.rd(a, v);
		chk(v, e);
	endtask
	// Counts and verdict
	task stop_test;
		$display("checks %0d errors %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		#160000;
		bad_count++;
		stop_test;
	end
	// Main sequence
	initial
	begin
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		rdc(BDC_OFS_BCTL, 32'h0);
		rdc(BDC_OFS_DIAG, 32'h0);
		foreach (rows[i])
		begin
			bdc_host_i.wr(rows[i].a, rows[i].d);
			rdc(rows[i].a, rows[i].e);
		end
		// Live insertion on, pin as input
		#1 chk({wr_disc_cacheline, upstream_prefetch, forward_byte_en, single_dword}, 4'hB);
		@(posedge sys_clk);
		gpio3_in <= 1'b1;
		#1 chk({io_en_eff, mem_en_eff, master_en_eff, accept_io, accept_mem}, 5'h0);
		@(posedge sys_clk);
		gpio3_is_input <= 1'b0;
		#1 chk({io_en_eff, mem_en_eff, master_en_eff, accept_io, accept_mem}, 5'h1F);
		@(posedge sys_clk);
		gpio3_is_input <= 1'b1;
		bdc_host_i.wr(BDC_OFS_DIAG, 32'h0);
		#1 chk({wr_disc_cacheline, upstream_prefetch, forward_byte_en, single_dword, io_en_eff, mem_en_eff,
			master_en_eff, accept_io, accept_mem}, 9'h09F);
		// Discard timer expiry, enabled then disabled
		@(posedge sys_clk);
		bdc_host_i.wr(BDC_OFS_BCTL, 32'h08000000);
		sec_disc_expire <= 1'b1;
		@(posedge sys_clk);
		sec_disc_expire <= 1'b0;
		#1 chk(primary_system_error_n, 1'b0);
		@(posedge sys_clk);
		bdc_host_i.wr(BDC_OFS_BCTL, 32'h0);
		pri_disc_expire <= 1'b1;
		@(posedge sys_clk);
		pri_disc_expire <= 1'b0;
		#1 chk(primary_system_error_n, 1'b1);
		// Chip reset with other bits set
		@(posedge sys_clk);
		bdc_host_i.wr(BDC_OFS_DIAG, 32'h122);
		rdc(BDC_OFS_DIAG, 32'h100);
		// Four-cycle sequence: the end of the write and the read back span three, one remains
		n = 0;
		#1;
		while (chip_reset !== 1'b0 && n < 20)
		begin
			@(posedge sys_clk);
			#1 n++;
		end
		chk(n, 32'h1);
		@(posedge sys_clk);
		rdc(BDC_OFS_DIAG, 32'h0);
		#1 chk(irq, 1'b0);
		@(posedge sys_clk);
		bdc_host_i.wr(BDC_OFS_IRQ_MASK, 32'h8);
		#1 chk(irq, 1'b1);
		@(posedge sys_clk);
		rdc(BDC_OFS_IRQ_STAT, 32'hC);
		#1 chk(irq, 1'b0);
		@(posedge sys_clk);
		rdc(BDC_OFS_IRQ_STAT, 32'h0);
		// Timeouts: primary long, secondary short and repeated
		bdc_host_i.wr(BDC_OFS_IRQ_MASK, 32'h2);
		bdc_host_i.wr(BDC_OFS_BCTL, 32'h02000000);
		pri_dt.head <= 1'b1;
		sec_dt.head <= 1'b1;
		sd = 1'b0;
		ns = 0;
		n = 0;
		while (pri_discard !== 1'b1 && n < 34000)
		begin
			@(posedge sys_clk);
			// Secondary repeats once, then leaves the front after its timeout
			sec_dt.repeated <= (n == 4);
			sec_dt.head <= (ns == 0);
			#1 n++;
			sd |= sec_discard;
			if (irq === 1'b1 && ns == 0)
				ns = n;
		end
		chk(32'(n >= 32768 && n <= 32772), 32'h1);
		chk(32'(ns >= 1024 && ns <= 1028), 32'h1);
		chk(sd, 1'b0);
		@(posedge sys_clk);
		pri_dt <= '0;
		sec_dt <= '0;
		rdc(BDC_OFS_BCTL, 32'h06000000);
		bdc_host_i.wr(BDC_OFS_BCTL, 32'h06000000);
		rdc(BDC_OFS_BCTL, 32'h02000000);
		stop_test;
	end
endmodule // tb
